// ---- pkg/bfpfm_regs.svh ----
// register offsets, field positions, reset values and counts of the queue port
`ifndef BFPFM_REGS_SVH
`define BFPFM_REGS_SVH
`define BFPFM_DEPTH 7'h40
`define BFPFM_LAST 7'h3f
`define BFPFM_ONE 7'h01
`define BFPFM_NONE 7'h00
`define BFPFM_PTR_ONE 6'h01
`define BFPFM_PTR_RST 6'h00
`define BFPFM_LW 9
`define BFPFM_LANES 4
`define BFPFM_THR_HH 5'h10
`define BFPFM_THR_HL 5'h0c
`define BFPFM_THR_LH 5'h08
`define BFPFM_THR_LL 5'h04
`define BFPFM_ADR_CTRL 4'h0
`define BFPFM_ADR_STAT 4'h4
`define BFPFM_ADR_LEVEL 4'h8
`define BFPFM_CTRL_ODD 0
`define BFPFM_CTRL_GEN_A 1
`define BFPFM_CTRL_GEN_B 2
`define BFPFM_CTRL_RST 3'h0
`define BFPFM_DATA_RST 36'h0
`define BFPFM_WORD_RST 32'h0
`endif

// ---- pkg/bfpfm_pkg.sv ----
// carrier types for the two queue ports
`default_nettype none
package bfpfm_pkg;
  typedef struct packed {
    logic select_n;
    logic xfer_enable;
    logic write_not_read;
    logic box_select;
    logic [35:0] data;
  } bfpfm_pa_in_type;
  typedef struct packed {
    logic select_n;
    logic xfer_enable;
    logic write_not_read;
    logic width_sel_hi;
    logic width_sel_lo;
    logic [35:0] data;
  } bfpfm_pb_in_type;
  typedef struct packed {
    logic [35:0] data;
    logic oe;
    logic empty_n;
    logic full_n;
    logic near_empty_n;
    logic near_full_n;
    logic parity_err_n;
    logic box_flag_n;
  } bfpfm_pa_out_type;
  typedef struct packed {
    logic [35:0] data;
    logic oe;
    logic empty_n;
    logic full_n;
    logic parity_err_n;
    logic box_flag_n;
  } bfpfm_pb_out_type;
endpackage : bfpfm_pkg
`default_nettype wire

// ---- design/bfpfm_top.sv ----
// two-direction queue port control: selects, flags, mailboxes and parity
`timescale 1ns/1ns
`default_nettype none
`include "bfpfm_regs.svh"
module bfpfm_top (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PORT_A_CLOCK,
  input wire logic PORT_B_CLOCK,
  input wire bfpfm_pkg::bfpfm_pa_in_type PORT_A_IN,
  input wire bfpfm_pkg::bfpfm_pb_in_type PORT_B_IN,
  input wire logic OFFSET_SELECT_HI,
  input wire logic OFFSET_SELECT_LO,
  output bfpfm_pkg::bfpfm_pa_out_type PORT_A_OUT,
  output bfpfm_pkg::bfpfm_pb_out_type PORT_B_OUT,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O
);
  bfpfm_pkg::bfpfm_pa_in_type pa_s1_ff, pa_s2_ff;
  bfpfm_pkg::bfpfm_pb_in_type pb_s1_ff, pb_s2_ff;
  logic [2:0] ca_ff, cb_ff;
  logic [1:0] fs_s1_ff, fs_s2_ff;
  logic rst_q_ff;
  logic [4:0] thr_ff;
  logic [2:0] ctrl_ff;
  logic [35:0] mem_ab [0:63];
  logic [35:0] mem_ba [0:63];
  logic [5:0] wp_ab_ff, rp_ab_ff, wp_ba_ff, rp_ba_ff;
  logic [6:0] cnt_ab_ff, cnt_ba_ff;
  logic [35:0] oreg_a_ff, oreg_b_ff, msg_ab_ff, msg_ba_ff;
  logic ea1_ff, ea_ff, eb1_ff, eb_ff, fa1_ff, fa_ff, fb1_ff, fb_ff;
  logic ae1_ff, ae_ff, af1_ff, af_ff;
  logic box1_ff, box2_ff;
  logic [35:0] pa_dout_ff, pb_dout_ff;
  logic pa_oe_ff, pb_oe_ff, perr_a_ff, perr_b_ff;
  logic [31:0] dat_ff;
  logic ack_ff;

  // two flops on every port and offset pin; only the second stage is read below. they run
  // through reset so idle pin levels and the offset code stand at release;
  // cleared stages would fake a selected port and hide the offset code
  always_ff @(posedge CLK_SYS) begin
    pa_s1_ff <= PORT_A_IN;
    pa_s2_ff <= pa_s1_ff;
    pb_s1_ff <= PORT_B_IN;
    pb_s2_ff <= pb_s1_ff;
    fs_s1_ff <= {OFFSET_SELECT_HI, OFFSET_SELECT_LO};
    fs_s2_ff <= fs_s1_ff;
  end

  // port clocks: two sync stages plus one for the edge detector; no reset,
  // since a cleared history would see a false rising edge on a high pin
  always_ff @(posedge CLK_SYS) begin
    ca_ff <= {ca_ff[1:0], PORT_A_CLOCK};
    cb_ff <= {cb_ff[1:0], PORT_B_CLOCK};
  end

  logic a_edge, b_edge, a_xfer, b_xfer, b_box;
  logic a_wr_q, a_box_wr, a_rd, a_box_rd;
  logic b_wr_q, b_box_wr, b_rd, b_box_rd;
  logic odd, gen_a, gen_b, force_a, force_b;
  assign a_edge = ca_ff[1] & ~ca_ff[2];
  assign b_edge = cb_ff[1] & ~cb_ff[2];
  // transfers need select low and enable high on the port edge
  assign a_xfer = a_edge & ~pa_s2_ff.select_n & pa_s2_ff.xfer_enable;
  assign b_xfer = b_edge & ~pb_s2_ff.select_n & pb_s2_ff.xfer_enable;
  assign b_box = pb_s2_ff.width_sel_hi & pb_s2_ff.width_sel_lo;
  // queue accesses gated by the flags, mailbox writes by box flags; mailbox reads are not gated
  assign a_wr_q = a_xfer & pa_s2_ff.write_not_read & ~pa_s2_ff.box_select
                  & fa_ff;
  assign a_box_wr = a_xfer & pa_s2_ff.write_not_read & pa_s2_ff.box_select
                    & box1_ff;
  assign a_rd = a_xfer & ~pa_s2_ff.write_not_read & ~pa_s2_ff.box_select
                & ea_ff;
  assign a_box_rd = a_xfer & ~pa_s2_ff.write_not_read
                    & pa_s2_ff.box_select;
  assign b_wr_q = b_xfer & pb_s2_ff.write_not_read & ~b_box & fb_ff;
  assign b_box_wr = b_xfer & pb_s2_ff.write_not_read & b_box
                    & box2_ff;
  assign b_rd = b_xfer & ~pb_s2_ff.write_not_read & ~b_box & eb_ff;
  assign b_box_rd = b_xfer & ~pb_s2_ff.write_not_read & b_box;
  assign odd = ctrl_ff[`BFPFM_CTRL_ODD];
  assign gen_a = ctrl_ff[`BFPFM_CTRL_GEN_A];
  assign gen_b = ctrl_ff[`BFPFM_CTRL_GEN_B];
  assign force_a = ~pa_s2_ff.write_not_read & pa_s2_ff.box_select & gen_a;
  assign force_b = ~pb_s2_ff.write_not_read & b_box & gen_b;

  // offset code is caught in the first cycle after reset release
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rst_q_ff <= 1'b1;
      thr_ff <= `BFPFM_THR_LL;
    end else begin
      rst_q_ff <= 1'b0;
      if (rst_q_ff) begin
        unique case (fs_s2_ff)
          2'h3: thr_ff <= `BFPFM_THR_HH;
          2'h2: thr_ff <= `BFPFM_THR_HL;
          2'h1: thr_ff <= `BFPFM_THR_LH;
          2'h0: thr_ff <= `BFPFM_THR_LL;
        endcase
      end
    end
  end

  // queue storage; data words need no reset
  always_ff @(posedge CLK_SYS) begin
    if (a_wr_q) begin
      mem_ab[wp_ab_ff] <= pa_s2_ff.data;
    end
    if (b_wr_q) begin
      mem_ba[wp_ba_ff] <= pb_s2_ff.data;
    end
  end

  // pointers and word counts; both ports may act in one cycle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      wp_ab_ff <= `BFPFM_PTR_RST;
      rp_ab_ff <= `BFPFM_PTR_RST;
      wp_ba_ff <= `BFPFM_PTR_RST;
      rp_ba_ff <= `BFPFM_PTR_RST;
      cnt_ab_ff <= `BFPFM_NONE;
      cnt_ba_ff <= `BFPFM_NONE;
    end else begin
      if (a_wr_q) wp_ab_ff <= wp_ab_ff + `BFPFM_PTR_ONE;
      if (b_rd) rp_ab_ff <= rp_ab_ff + `BFPFM_PTR_ONE;
      if (b_wr_q) wp_ba_ff <= wp_ba_ff + `BFPFM_PTR_ONE;
      if (a_rd) rp_ba_ff <= rp_ba_ff + `BFPFM_PTR_ONE;
      cnt_ab_ff <= cnt_ab_ff + {6'h0, a_wr_q} - {6'h0, b_rd};
      cnt_ba_ff <= cnt_ba_ff + {6'h0, b_wr_q} - {6'h0, a_rd};
    end
  end

  // port-A flags: two stages on port-A edges; a read or write that
  // empties or fills the queue drops the flag at once, never late
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      {ea1_ff, ea_ff, fa1_ff, fa_ff, ae1_ff, ae_ff} <= 6'h0;
      af1_ff <= 1'b1;
      af_ff <= 1'b1;
    end else if (a_edge) begin
      if (a_rd && cnt_ba_ff == `BFPFM_ONE) begin
        ea1_ff <= 1'b0;
        ea_ff <= 1'b0;
      end else begin
        ea1_ff <= cnt_ba_ff != `BFPFM_NONE;
        ea_ff <= ea1_ff;
      end
      if (a_wr_q && cnt_ab_ff == `BFPFM_LAST) begin
        fa1_ff <= 1'b0;
        fa_ff <= 1'b0;
      end else begin
        fa1_ff <= cnt_ab_ff != `BFPFM_DEPTH;
        fa_ff <= fa1_ff;
      end
      ae1_ff <= cnt_ba_ff > {2'h0, thr_ff};
      ae_ff <= ae1_ff;
      af1_ff <= (`BFPFM_DEPTH - cnt_ab_ff) > {2'h0, thr_ff};
      af_ff <= af1_ff;
    end
  end

  // port-B flags, same scheme on port-B edges
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      {eb1_ff, eb_ff, fb1_ff, fb_ff} <= 4'h0;
    end else if (b_edge) begin
      if (b_rd && cnt_ab_ff == `BFPFM_ONE) begin
        eb1_ff <= 1'b0;
        eb_ff <= 1'b0;
      end else begin
        eb1_ff <= cnt_ab_ff != `BFPFM_NONE;
        eb_ff <= eb1_ff;
      end
      if (b_wr_q && cnt_ba_ff == `BFPFM_LAST) begin
        fb1_ff <= 1'b0;
        fb_ff <= 1'b0;
      end else begin
        fb1_ff <= cnt_ba_ff != `BFPFM_DEPTH;
        fb_ff <= fb1_ff;
      end
    end
  end

  // output registers and mailboxes
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      oreg_a_ff <= `BFPFM_DATA_RST;
      oreg_b_ff <= `BFPFM_DATA_RST;
      msg_ab_ff <= `BFPFM_DATA_RST;
      msg_ba_ff <= `BFPFM_DATA_RST;
    end else begin
      if (a_rd) oreg_a_ff <= mem_ba[rp_ba_ff];
      if (b_rd) oreg_b_ff <= mem_ab[rp_ab_ff];
      if (a_box_wr) msg_ab_ff <= pa_s2_ff.data;
      if (b_box_wr) msg_ba_ff <= pb_s2_ff.data;
    end
  end

  // mail flags: a write marks mail; it wins over a same-cycle read
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      box1_ff <= 1'b1;
      box2_ff <= 1'b1;
    end else begin
      if (a_box_wr) box1_ff <= 1'b0;
      else if (b_box_rd) box1_ff <= 1'b1;
      if (b_box_wr) box2_ff <= 1'b0;
      else if (a_box_rd) box2_ff <= 1'b1;
    end
  end

  // per-lane check and generation; mailbox read shares the generation trees
  logic [35:0] pa_src, pb_src, pa_gd, pb_gd;
  logic [3:0] ok_a, ok_b;
  assign pa_src = pa_s2_ff.box_select ? msg_ba_ff : oreg_a_ff;
  assign pb_src = b_box ? msg_ab_ff : oreg_b_ff;
  for (genvar i = 0; i < `BFPFM_LANES; i++) begin : g_lane
    assign ok_a[i] = (^pa_s2_ff.data[`BFPFM_LW*i +: `BFPFM_LW]) == odd;
    assign ok_b[i] = (^pb_s2_ff.data[`BFPFM_LW*i +: `BFPFM_LW]) == odd;
    assign pa_gd[`BFPFM_LW*i +: `BFPFM_LW] = {gen_a
      ? (^pa_src[`BFPFM_LW*i +: 8]) ^ odd
      : pa_src[`BFPFM_LW*i + 8], pa_src[`BFPFM_LW*i +: 8]};
    assign pb_gd[`BFPFM_LW*i +: `BFPFM_LW] = {gen_b
      ? (^pb_src[`BFPFM_LW*i +: 8]) ^ odd
      : pb_src[`BFPFM_LW*i + 8], pb_src[`BFPFM_LW*i +: 8]};
  end

  // pin drivers registered so every output comes from a flop
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pa_dout_ff <= `BFPFM_DATA_RST;
      pb_dout_ff <= `BFPFM_DATA_RST;
      pa_oe_ff <= 1'b0;
      pb_oe_ff <= 1'b0;
      perr_a_ff <= 1'b1;
      perr_b_ff <= 1'b1;
    end else begin
      pa_dout_ff <= pa_gd;
      pb_dout_ff <= pb_gd;
      pa_oe_ff <= ~pa_s2_ff.select_n & ~pa_s2_ff.write_not_read;
      pb_oe_ff <= ~pb_s2_ff.select_n & ~pb_s2_ff.write_not_read;
      perr_a_ff <= force_a | (&ok_a);
      perr_b_ff <= force_b | (&ok_b);
    end
  end

  // wishbone slave: one wait cycle, unmapped reads return zero
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ack_ff <= 1'b0;
      dat_ff <= `BFPFM_WORD_RST;
      ctrl_ff <= `BFPFM_CTRL_RST;
    end else begin
      ack_ff <= CYC_I & STB_I & ~ack_ff;
      if (CYC_I && STB_I && !ack_ff && WE_I && SEL_I[0]
          && ADR_I == `BFPFM_ADR_CTRL) begin
        ctrl_ff <= DAT_I[2:0];
      end
      unique case (ADR_I)
        `BFPFM_ADR_CTRL: dat_ff <= {29'h0, ctrl_ff};
        `BFPFM_ADR_STAT: dat_ff <= {22'h0, box2_ff, box1_ff, perr_b_ff,
          perr_a_ff, af_ff, ae_ff, fb_ff, fa_ff, eb_ff, ea_ff};
        `BFPFM_ADR_LEVEL: dat_ff <= {11'h0, thr_ff, 1'b0, cnt_ba_ff,
          1'b0, cnt_ab_ff};
        default: dat_ff <= `BFPFM_WORD_RST;
      endcase
    end
  end

  assign ACK_O = ack_ff;
  assign DAT_O = dat_ff;
  assign PORT_A_OUT = {pa_dout_ff, pa_oe_ff, ea_ff, fa_ff, ae_ff, af_ff,
    perr_a_ff, box1_ff};
  assign PORT_B_OUT = {pb_dout_ff, pb_oe_ff, eb_ff, fb_ff, perr_b_ff, box2_ff};

  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  full_rise_a_a: assert property ($rose(fa_ff) |-> $past(a_edge) && $past(fa1_ff))
    else $error("port-A full flag rose without two port-A edges");
  empty_rise_a_a: assert property ($rose(ea_ff) |-> $past(a_edge) && $past(ea1_ff))
    else $error("port-A empty flag rose without two port-A edges");
  empty_block_a_a: assert property (!ea_ff |=> $stable(rp_ba_ff))
    else $error("B-to-A queue read while flagged empty");
  full_block_a_a: assert property (!fa_ff |=> $stable(wp_ab_ff))
    else $error("A-to-B queue written while flagged full");
  pin_float_a_a: assert property (pa_s2_ff.select_n |=> !pa_oe_ff)
    else $error("port-A driven while deselected");
  box_write_a_a: assert property (a_box_wr |=> !box1_ff ##0 msg_ab_ff == $past(pa_s2_ff.data))
    else $error("A-to-B mailbox write did not mark mail");
  box_read_b_a: assert property (b_box_rd && !a_box_wr |=> box1_ff)
    else $error("port-B mailbox read did not clear mail flag");
  box_read_a_a: assert property (a_box_rd && !b_box_wr |=> box2_ff)
    else $error("port-A mailbox read did not clear mail flag");
  parity_force_a: assert property (force_a |=> perr_a_ff)
    else $error("parity error shown during generated mailbox read");
  offset_load_a: assert property (rst_q_ff && fs_s2_ff == 2'h3 |=> thr_ff == 5'h10)
    else $error("offset code 3 did not load 16");
  pin_float_b_a: assert property (pb_s2_ff.select_n |=> !pb_oe_ff)
    else $error("port-B driven while deselected");
  box_hold_ab_a: assert property (!box1_ff |=> $stable(msg_ab_ff))
    else $error("A-to-B mailbox overwritten while mail present");
  box_hold_ba_a: assert property (!box2_ff |=> $stable(msg_ba_ff))
    else $error("B-to-A mailbox overwritten while mail present");
endmodule : bfpfm_top
`default_nettype wire

// ---- bench/bfpfm_port_model.sv ----
// far-side model: two free-running port clocks and port masters
`timescale 1ns/1ns
`default_nettype none
module bfpfm_port_model (
  input wire logic clk,
  output logic pa_clk,
  output logic pb_clk,
  output bfpfm_pkg::bfpfm_pa_in_type pa_in,
  output bfpfm_pkg::bfpfm_pb_in_type pb_in,
  input wire bfpfm_pkg::bfpfm_pa_out_type pa_out,
  input wire bfpfm_pkg::bfpfm_pb_out_type pb_out
);
  logic [3:0] cnt_a;
  logic [3:0] cnt_b;
  // idle: deselected, disabled, pins showing a pattern, not old data
  initial begin
    pa_clk = 1'h0;
    pb_clk = 1'h0;
    cnt_a = 4'h0;
    cnt_b = 4'h0;
    pa_in = {4'h8, 36'h5_5555_5555};
    pb_in = {5'h10, 36'ha_aaaa_aaaa};
  end
  // port clocks run free at unrelated rates, 6 and 7 cycles per half
  always @(posedge clk) begin
    cnt_a <= (cnt_a == 4'h5) ? 4'h0 : cnt_a + 4'h1;
    cnt_b <= (cnt_b == 4'h6) ? 4'h0 : cnt_b + 4'h1;
    if (cnt_a == 4'h5) pa_clk <= ~pa_clk;
    if (cnt_b == 4'h6) pb_clk <= ~pb_clk;
  end
  // c is {select_n, enable, write_not_read, box_select}; held past the edge
  task automatic xfer_a(input logic [3:0] c, input logic [35:0] d,
      output bfpfm_pkg::bfpfm_pa_out_type q);
    @(negedge pa_clk);
    @(posedge clk);
    pa_in <= {c, d};
    @(posedge pa_clk);
    repeat (5) @(posedge clk);
    q = pa_out;
    pa_in <= {1'h1, 1'h0, c[1:0], ~d}; // released pins flip
  endtask : xfer_a
  // c is {select_n, enable, write_not_read, width_sel_hi, width_sel_lo}
  task automatic xfer_b(input logic [4:0] c, input logic [35:0] d,
      output bfpfm_pkg::bfpfm_pb_out_type q);
    @(negedge pb_clk);
    @(posedge clk);
    pb_in <= {c, d};
    @(posedge pb_clk);
    repeat (5) @(posedge clk);
    q = pb_out;
    pb_in <= {1'h1, 1'h0, c[2:0], ~d}; // released pins flip
  endtask : xfer_b
endmodule : bfpfm_port_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the queue port control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, srst, pa_clk, pb_clk, ofs_hi, ofs_lo;
  logic cyc, stb, we, ack;
  logic [3:0] adr, sel;
  logic [31:0] dat_i, dat_o, w;
  bfpfm_pkg::bfpfm_pa_in_type pa_in;
  bfpfm_pkg::bfpfm_pb_in_type pb_in;
  bfpfm_pkg::bfpfm_pa_out_type pa_out, qa;
  bfpfm_pkg::bfpfm_pb_out_type pb_out, qb;
  int errors = 0;
  int check_count = 0;
  logic [4:0] thr [4] = '{5'h04, 5'h08, 5'h0c, 5'h10};

  bfpfm_top DUT (.CLK_SYS(clk), .SRST(srst), .PORT_A_CLOCK(pa_clk),
    .PORT_B_CLOCK(pb_clk), .PORT_A_IN(pa_in), .PORT_B_IN(pb_in),
    .OFFSET_SELECT_HI(ofs_hi), .OFFSET_SELECT_LO(ofs_lo),
    .PORT_A_OUT(pa_out), .PORT_B_OUT(pb_out), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o),
    .ACK_O(ack));
  bfpfm_port_model pm (.clk(clk), .pa_clk(pa_clk), .pb_clk(pb_clk),
    .pa_in(pa_in), .pb_in(pb_in), .pa_out(pa_out), .pb_out(pb_out));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic print_verdict;
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t flag got %b exp %b", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [35:0] g, input logic [35:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t word got %h exp %h", $time, g, e);
    end
  endtask : chk_word

  // classic single cycle; the request stands until ack is sampled
  task automatic wb(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= wr;
    adr <= a;
    sel <= 4'hf;
    dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'h1) break;
    end
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n == 20) begin
      errors++;
      print_verdict();
    end
    @(posedge clk);
  endtask : wb

  function automatic logic flag(input int f);
    case (f)
      0: return pa_out.empty_n;
      1: return pb_out.empty_n;
      2: return pa_out.full_n;
      default: return pb_out.full_n;
    endcase
  endfunction : flag

  // flags move on slow port edges, so allow a bounded number of cycles
  task automatic wait_flag(input int f, input logic v);
    int n;
    for (n = 0; n < 80 && flag(f) !== v; n++) @(posedge clk);
    chk_bit(flag(f), v);
  endtask : wait_flag

  // offset pins settle with reset high, well before its release
  task automatic do_reset(input logic [1:0] c);
    @(posedge clk);
    srst <= 1'h1;
    ofs_hi <= c[1];
    ofs_lo <= c[0];
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    chk_word({28'h0, pa_out.empty_n, pb_out.empty_n, pa_out.full_n,
      pb_out.full_n, pa_out.near_empty_n, pa_out.near_full_n,
      pa_out.box_flag_n, pb_out.box_flag_n}, 36'h7);
  endtask : do_reset

  // expected read word with each lane's top bit regenerated
  function automatic logic [35:0] gen(input logic [35:0] d, input logic odd);
    for (int i = 0; i < 4; i++) d[9*i+8] = ^d[9*i +: 8] ^ odd;
    return d;
  endfunction : gen

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    srst = 1'h1;
    ofs_hi = 1'h0;
    ofs_lo = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 4'h0;
    sel = 4'h0;
    dat_i = 32'h0;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1:0]);
      wb(1'h0, 4'h8, 32'h0, w);
      chk_word({31'h0, w[20:16]}, {31'h0, thr[k]});
    end
    wait_flag(2, 1'h1);
    wait_flag(3, 1'h1);
    pm.xfer_a(4'he, 36'h0_0000_0003, qa);
    chk_bit(qa.oe, 1'h0);
    pm.xfer_a(4'hc, 36'h0_0000_0003, qa);
    chk_bit(qa.oe, 1'h0);
    pm.xfer_a(4'h2, 36'h0_0000_0003, qa);
    repeat (40) @(posedge clk);
    chk_bit(pb_out.empty_n, 1'h0);
    pm.xfer_a(4'h6, 36'h0_0000_0003, qa);
    chk_bit(qa.oe, 1'h0);
    chk_bit(qa.parity_err_n, 1'h1);
    wait_flag(1, 1'h1);
    pm.xfer_b(5'h08, 36'h0, qb);
    chk_bit(qb.oe, 1'h1);
    chk_word(qb.data, 36'h0_0000_0003);
    chk_bit(pb_out.empty_n, 1'h0);
    pm.xfer_b(5'h0c, 36'h9_8765_4321, qb);
    chk_bit(qb.parity_err_n, 1'h0);
    wait_flag(0, 1'h1);
    chk_bit(pa_out.near_empty_n, 1'h0);
    pm.xfer_a(4'h4, 36'h0, qa);
    chk_word(qa.data, 36'h9_8765_4321);
    pm.xfer_a(4'h7, 36'h0_aaaa_5555, qa);
    chk_bit(pa_out.box_flag_n, 1'h0);
    pm.xfer_a(4'h7, 36'h0_1111_2222, qa);
    chk_bit(pb_out.empty_n, 1'h0);
    pm.xfer_b(5'h0b, 36'h0, qb);
    chk_word(qb.data, 36'h0_aaaa_5555);
    chk_bit(pa_out.box_flag_n, 1'h1);
    wb(1'h1, 4'h0, 32'h7, w);
    wb(1'h0, 4'h0, 32'h0, w);
    chk_word({4'h0, w}, 36'h7);
    pm.xfer_b(5'h0f, 36'h0_1234_5678, qb);
    chk_bit(pb_out.box_flag_n, 1'h0);
    pm.xfer_a(4'h5, 36'h0, qa);
    chk_word(qa.data, gen(36'h0_1234_5678, 1'h1));
    chk_bit(qa.parity_err_n, 1'h1);
    chk_bit(pb_out.box_flag_n, 1'h1);
    pm.xfer_b(5'h0b, 36'h0, qb);
    chk_word(qb.data, gen(36'h0_aaaa_5555, 1'h1));
    wb(1'h1, 4'h0, 32'h1, w);
    pm.xfer_a(4'h6, 36'h0, qa);
    chk_bit(qa.parity_err_n, 1'h0);
    wb(1'h1, 4'h0, 32'h0, w);
    pm.xfer_a(4'h6, 36'h8_0000_0000, qa);
    chk_bit(qa.parity_err_n, 1'h0);
    wb(1'h0, 4'hc, 32'h0, w);
    chk_word({4'h0, w}, 36'h0);
    wb(1'h0, 4'h4, 32'h0, w);
    chk_word({31'h0, w[9:8], w[3:2], w[0]}, 36'h1e);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
